// file: core/readout_sequencer.sv
// readout sequencer: sample capture, channel stepping, driver control
`timescale 1ns/1ps
module readout_sequencer
    import readout_pkg::*;
(
    input  wire logic                              clk,
    input  wire logic                              resetn,
    input  wire logic                              read_start_in,
    input  wire logic                              integrator_reset,
    input  wire logic                              signal_sample_strobe,
    input  wire logic                              parallel_out_select,
    input  wire logic                              hiz_after_read_en,
    input  wire logic                              integrate_polarity_n,
    input  wire logic                              sampleValid,
    output logic                                   sampleReady,
    input  wire logic [readout_pkg::CHAN_W-1:0]    sampleChan,
    input  wire logic [readout_pkg::SAMPLE_W-1:0]  sampleData,
    output logic      [readout_pkg::SAMPLE_W-1:0]  drv1Data,
    output logic      [readout_pkg::CHAN_W-1:0]    drv1Chan,
    output logic                                   drv1Valid,
    output logic                                   drv1Hiz,
    output logic      [readout_pkg::SAMPLE_W-1:0]  drv0Data,
    output logic      [readout_pkg::CHAN_W-1:0]    drv0Chan,
    output logic                                   drv0Valid,
    output logic                                   drv0Hiz,
    output logic                                   refSwap,
    output logic                                   readDone,
    output logic                                   read_start_out
);
    import readout_pkg::*;

    localparam int FW = CHAN_W + SAMPLE_W;

    // pin synchronisers
    logic [1:0] startSync_ff;
    logic [1:0] irstSync_ff;
    logic [1:0] shsSync_ff;
    logic [1:0] modeSync_ff;
    logic [1:0] hizSync_ff;
    logic [1:0] polSync_ff;
    logic       startPrev_ff;
    logic       irstPrev_ff;
    logic       shsPrev_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            startSync_ff <= 2'h0;
            irstSync_ff  <= 2'h0;
            shsSync_ff   <= 2'h0;
            modeSync_ff  <= 2'h0;
            hizSync_ff   <= 2'h0;
            polSync_ff   <= 2'h0;
        end else begin
            startSync_ff <= {startSync_ff[0], read_start_in};
            irstSync_ff  <= {irstSync_ff[0], integrator_reset};
            shsSync_ff   <= {shsSync_ff[0], signal_sample_strobe};
            modeSync_ff  <= {modeSync_ff[0], parallel_out_select};
            hizSync_ff   <= {hizSync_ff[0], hiz_after_read_en};
            polSync_ff   <= {polSync_ff[0], integrate_polarity_n};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            startPrev_ff <= 1'b0;
            irstPrev_ff  <= 1'b0;
            shsPrev_ff   <= 1'b0;
        end else begin
            startPrev_ff <= startSync_ff[1];
            irstPrev_ff  <= irstSync_ff[1];
            shsPrev_ff   <= shsSync_ff[1];
        end
    end

    logic startRise;
    logic startFall;
    logic irstRise;
    logic shsRise;
    logic shsFall;
    logic simult;
    assign startRise = startSync_ff[1] && !startPrev_ff;
    assign startFall = !startSync_ff[1] && startPrev_ff;
    assign irstRise  = irstSync_ff[1] && !irstPrev_ff;
    assign shsRise   = shsSync_ff[1] && !shsPrev_ff;
    assign shsFall   = !shsSync_ff[1] && shsPrev_ff;
    assign simult    = modeSync_ff[1];
    assign refSwap   = polSync_ff[1];

    // sample intake through the FIFO into a single store
    logic          fifoValid;
    logic [FW-1:0] fifoData;
    logic          capBank_ff;
    logic          rdBank_ff;
    logic          capOpen_ff;

    sample_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk      (clk),
        .resetn   (resetn),
        .inValid  (sampleValid),
        .inReady  (sampleReady),
        .inData   ({sampleChan, sampleData}),
        .outValid (fifoValid),
        .outReady (capOpen_ff),
        .outData  (fifoData)
    );

    // samples flow while the signal strobe is high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            capOpen_ff <= 1'b0;
        end else if (shsRise) begin
            capOpen_ff <= 1'b1;
        end else if (shsFall) begin
            capOpen_ff <= 1'b0;
        end
    end

    // strobe fall swaps the capture and read bank flags
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            capBank_ff <= 1'b0;
            rdBank_ff  <= 1'b1;
        end else if (shsFall) begin
            capBank_ff <= ~capBank_ff;
            rdBank_ff  <= capBank_ff;
        end
    end

    // sequencer state
    seq_state_t       state_ff;
    seq_state_t       nxt_state;
    logic [IDX_W-1:0] idx1_ff;
    logic [IDX_W-1:0] idx0_ff;
    logic [STEP_W-1:0] phase_ff;
    logic             run1_ff;
    logic             run0_ff;
    logic             done1_ff;
    logic             done0_ff;
    logic             waitReq_ff;
    logic             irstSeen_ff;
    logic             startSeen_ff;
    logic             present1;
    logic             present0;

    // start after sample strobe, before reset: wait after read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waitReq_ff <= 1'b0;
        end else if (shsRise) begin
            waitReq_ff <= 1'b1;
        end else if (irstRise) begin
            waitReq_ff <= 1'b0;
        end
    end

    logic readEnd;
    assign readEnd = (state_ff == ST_READ) && done1_ff && done0_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (startRise) begin
                    nxt_state = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (startFall) begin
                    nxt_state = ST_READ;
                end
            end
            ST_READ: begin
                if (readEnd) begin
                    nxt_state = waitReq_ff ? ST_WAIT : ST_IDLE;
                end
            end
            ST_WAIT: begin
                if ((irstSeen_ff || irstRise) &&
                    (startSeen_ff || startRise)) begin
                    // a start still high arms the read at once
                    nxt_state = startSync_ff[1] ? ST_ARMED : ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // edge memory for leaving the wait state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irstSeen_ff  <= 1'b0;
            startSeen_ff <= 1'b0;
        end else if (state_ff != ST_WAIT) begin
            irstSeen_ff  <= 1'b0;
            startSeen_ff <= 1'b0;
        end else begin
            irstSeen_ff  <= irstSeen_ff || irstRise;
            startSeen_ff <= startSeen_ff || startRise;
        end
    end

    // clock phase inside a four-clock sequential step
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_ff <= STEP_RST;
        end else if (startRise) begin
            phase_ff <= STEP_RST;
        end else if (state_ff == ST_READ && !simult) begin
            phase_ff <= phase_ff + 2'h1;
        end
    end

    assign present1 = simult || phase_ff == STEP_RST;
    assign present0 = simult ? 1'b1 : phase_ff == STEP_SKEW;

    // driver 1 channel counter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idx1_ff  <= IDX_RST;
            run1_ff  <= 1'b0;
            done1_ff <= 1'b0;
        end else if (startRise) begin
            idx1_ff  <= IDX_RST;
            run1_ff  <= 1'b0;
            done1_ff <= 1'b0;
        end else if (state_ff == ST_READ && !done1_ff && present1) begin
            if (!run1_ff) begin
                run1_ff <= 1'b1;
            end else if (idx1_ff == LAST_IDX) begin
                done1_ff <= 1'b1;
            end else begin
                idx1_ff <= idx1_ff + 5'h01;
            end
        end
    end

    // driver 0 channel counter, two clocks behind in sequential mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idx0_ff  <= IDX_RST;
            run0_ff  <= 1'b0;
            done0_ff <= 1'b0;
        end else if (startRise) begin
            idx0_ff  <= IDX_RST;
            run0_ff  <= 1'b0;
            done0_ff <= 1'b0;
        end else if (state_ff == ST_READ && !done0_ff && present0) begin
            if (!run0_ff) begin
                run0_ff <= 1'b1;
            end else if (idx0_ff == LAST_IDX) begin
                done0_ff <= 1'b1;
            end else begin
                idx0_ff <= idx0_ff + 5'h01;
            end
        end
    end

    // store access: capture writes and two registered read ports
    logic [SAMPLE_W-1:0] rd1;
    logic [SAMPLE_W-1:0] rd0;
    logic [CHAN_W-1:0]   chan1;
    logic [CHAN_W-1:0]   chan0;
    assign chan1 = chanOf(1'b1, idx1_ff);
    assign chan0 = chanOf(1'b0, idx0_ff);

    sample_store u_store (
        .clk     (clk),
        .wrEn    (fifoValid && capOpen_ff),
        .wrAddr  (fifoData[FW-1:SAMPLE_W]),
        .wrData  (fifoData[SAMPLE_W-1:0]),
        .rdAddrA (chan1),
        .rdAddrB (chan0),
        .rdDataA (rd1),
        .rdDataB (rd0)
    );

    // only the bank swap is tracked; one store holds the readable scan
    logic unusedBank;
    assign unusedBank = capBank_ff ^ rdBank_ff;

    // data is the store's read register, aligned with the registered chan
    assign drv1Data = rd1;
    assign drv0Data = rd0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drv1Chan <= '0;
            drv0Chan <= '0;
        end else begin
            drv1Chan <= chan1;
            drv0Chan <= chan0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drv1Valid <= 1'b0;
            drv0Valid <= 1'b0;
        end else begin
            drv1Valid <= run1_ff && !done1_ff && state_ff == ST_READ;
            drv0Valid <= run0_ff && !done0_ff && state_ff == ST_READ;
        end
    end

    // high impedance after a driver finishes, if enabled
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drv1Hiz <= 1'b0;
            drv0Hiz <= 1'b0;
        end else begin
            drv1Hiz <= hizSync_ff[1] && done1_ff;
            drv0Hiz <= hizSync_ff[1] && done0_ff;
        end
    end

    // read-done flag and cascade start
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readDone       <= 1'b1;
            read_start_out <= 1'b0;
        end else begin
            readDone       <= !(nxt_state == ST_ARMED ||
                                nxt_state == ST_READ);
            read_start_out <= startSync_ff[1] && unusedBank;
        end
    end
endmodule : readout_sequencer

// file: core/sample_fifo.sv
// parameterised valid/ready FIFO for incoming samples
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] buf_ff [DEPTH];
    logic [AW:0]      wrPtr_ff;
    logic [AW:0]      rdPtr_ff;
    logic             full;
    logic             empty;
    logic             doWr;
    logic             doRd;

    assign empty    = wrPtr_ff == rdPtr_ff;
    assign full     = (wrPtr_ff[AW] != rdPtr_ff[AW]) &&
                      (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
    assign inReady  = !full;
    assign outValid = !empty;
    assign outData  = buf_ff[rdPtr_ff[AW-1:0]];
    assign doWr     = inValid && !full;
    assign doRd     = outReady && !empty;

    always_ff @(posedge clk) begin
        if (doWr) begin
            buf_ff[wrPtr_ff[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_ff <= '0;
        end else if (doWr) begin
            wrPtr_ff <= wrPtr_ff + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdPtr_ff <= '0;
        end else if (doRd) begin
            rdPtr_ff <= rdPtr_ff + 1'b1;
        end
    end
endmodule : sample_fifo

// file: core/sample_store.sv
// 64-word sample memory with registered read ports
`timescale 1ns/1ps
module sample_store
    import readout_pkg::*;
(
    input  wire logic                              clk,
    input  wire logic                              wrEn,
    input  wire logic [readout_pkg::CHAN_W-1:0]    wrAddr,
    input  wire logic [readout_pkg::SAMPLE_W-1:0]  wrData,
    input  wire logic [readout_pkg::CHAN_W-1:0]    rdAddrA,
    input  wire logic [readout_pkg::CHAN_W-1:0]    rdAddrB,
    output logic      [readout_pkg::SAMPLE_W-1:0]  rdDataA,
    output logic      [readout_pkg::SAMPLE_W-1:0]  rdDataB
);
    logic [SAMPLE_W-1:0] mem [CHAN_COUNT];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        rdDataA <= mem[rdAddrA];
        rdDataB <= mem[rdAddrB];
    end
endmodule : sample_store

// file: include/readout_pkg.sv
// constants and types shared by the readout sequencer files
package readout_pkg;
    localparam int CHAN_COUNT      = 64;
    localparam int CHAN_W          = 6;
    localparam int SAMPLE_W        = 16;
    localparam int HALF_COUNT      = 32;
    localparam int IDX_W           = 5;
    localparam int SEQ_STEP_CLKS   = 4;
    localparam int SEQ_SKEW_CLKS   = 2;
    localparam int STEP_W          = 2;
    localparam int FIFO_DEPTH      = 16;
    localparam int FIFO_AW         = 4;
    localparam logic [IDX_W-1:0] LAST_IDX = 5'h1F;
    localparam logic [STEP_W-1:0] STEP_LAST = 2'h3;
    localparam logic [STEP_W-1:0] STEP_SKEW = 2'h2;
    localparam logic [STEP_W-1:0] STEP_RST  = 2'h0;
    localparam logic [IDX_W-1:0]  IDX_RST   = 5'h00;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_READ  = 2'b11,
        ST_WAIT  = 2'b10
    } seq_state_t;

    // channel number on a driver for step index idx (idx 0 = highest)
    function automatic logic [CHAN_W-1:0] chanOf(input logic drv,
                                                  input logic [IDX_W-1:0] idx);
        chanOf = {drv, ~idx};
    endfunction : chanOf
endpackage : readout_pkg

// file: verif/ctrl_adc_model.sv
// timing controller and converter model facing the sequencer
`timescale 1ns/1ps
module ctrl_adc_model
    import readout_pkg::*;
(
    input  wire logic                             clk,
    output logic                                  read_start_in,
    output logic                                  integrator_reset,
    output logic                                  signal_sample_strobe,
    output logic                                  sampleValid,
    input  wire logic                             sampleReady,
    output logic      [readout_pkg::CHAN_W-1:0]   sampleChan,
    output logic      [readout_pkg::SAMPLE_W-1:0] sampleData,
    input  wire logic [readout_pkg::SAMPLE_W-1:0] drv1Data,
    input  wire logic [readout_pkg::CHAN_W-1:0]   drv1Chan,
    input  wire logic                             drv1Valid,
    input  wire logic [readout_pkg::SAMPLE_W-1:0] drv0Data,
    input  wire logic [readout_pkg::CHAN_W-1:0]   drv0Chan,
    input  wire logic                             drv0Valid
);
    logic [readout_pkg::SAMPLE_W-1:0] got [readout_pkg::CHAN_COUNT];
    logic [readout_pkg::CHAN_W-1:0]   first1;
    logic [readout_pkg::CHAN_W-1:0]   first0;
    int                               cnt1 = 0;
    int                               cnt0 = 0;

    initial begin
        read_start_in = 1'b0;
        integrator_reset = 1'b0;
        signal_sample_strobe = 1'b0;
        sampleValid = 1'b0;
        sampleChan = 6'h00;
        sampleData = 16'h0000;
    end

    // converter: latch each presented channel and count cycles
    always @(posedge clk) begin
        if (drv1Valid === 1'b1) begin
            if (cnt1 == 0) first1 <= drv1Chan;
            got[drv1Chan] <= drv1Data;
            cnt1 <= cnt1 + 1;
        end
        if (drv0Valid === 1'b1) begin
            if (cnt0 == 0) first0 <= drv0Chan;
            got[drv0Chan] <= drv0Data;
            cnt0 <= cnt0 + 1;
        end
    end

    task automatic clearCap();
        cnt1 = 0;
        cnt0 = 0;
        for (int i = 0; i < CHAN_COUNT; i++) got[i] = 'x;
    endtask : clearCap

    // start pulse, optionally with the integrator reset
    task automatic pulseStart(input logic withReset);
        @(posedge clk);
        #1;
        read_start_in = 1'b1;
        integrator_reset = withReset;
        repeat (3) @(posedge clk);
        #1;
        read_start_in = 1'b0;
        integrator_reset = 1'b0;
    endtask : pulseStart

    task automatic setShs(input logic v);
        @(posedge clk);
        #1;
        signal_sample_strobe = v;
    endtask : setShs

    // valid stays up until taken, also on timeout
    task automatic push(input logic [CHAN_W-1:0] c,
                        input logic [SAMPLE_W-1:0] d, output bit ok);
        if (sampleValid !== 1'b1) begin
            @(posedge clk);
            #1;
            sampleValid = 1'b1;
            sampleChan = c;
            sampleData = d;
        end
        ok = 1'b0;
        for (int n = 0; n < 12 && !ok; n++) begin
            @(posedge clk);
            ok = (sampleReady === 1'b1);
        end
        #1;
        if (ok) begin
            sampleValid = 1'b0;
            sampleChan = ~c;
            sampleData = ~d;
        end
    endtask : push
endmodule : ctrl_adc_model

// file: verif/readout_checker.sv
// concurrent checks on the readout sequencer ports
`timescale 1ns/1ps
module readout_checker
    import readout_pkg::*;
(
    input wire logic                           clk,
    input wire logic                           resetn,
    input wire logic                           parallel_out_select,
    input wire logic                           hiz_after_read_en,
    input wire logic                           integrate_polarity_n,
    input wire logic [readout_pkg::CHAN_W-1:0] drv1Chan,
    input wire logic                           drv1Valid,
    input wire logic                           drv1Hiz,
    input wire logic [readout_pkg::CHAN_W-1:0] drv0Chan,
    input wire logic                           drv0Valid,
    input wire logic                           drv0Hiz,
    input wire logic                           refSwap,
    input wire logic                           readDone
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_drv1_upper: assert property (drv1Valid |-> drv1Chan[5])
        else $error("low chan on drv1");
    a_drv0_lower: assert property (drv0Valid |-> !drv0Chan[5])
        else $error("high chan on drv0");
    a_first_chan: assert property ($rose(drv1Valid)
        |-> drv1Chan == 6'h3F)
        else $error("first chan not 63");
    a_seq_hold: assert property ((!parallel_out_select && drv1Valid &&
        ($changed(drv1Chan) || $rose(drv1Valid)))
        |-> ##1 (drv1Valid && $stable(drv1Chan))[*3])
        else $error("chan held under 4 clocks");
    a_step_down: assert property ((drv1Valid && $past(drv1Valid) &&
        $changed(drv1Chan)) |-> drv1Chan == $past(drv1Chan) - 6'h01)
        else $error("chan step not -1");
    a_seq_skew: assert property ((!parallel_out_select &&
        $rose(drv1Valid)) |-> !drv0Valid ##2 $rose(drv0Valid))
        else $error("drv0 skew not 2");
    a_sim_pair: assert property ((parallel_out_select && drv1Valid)
        |-> drv0Valid && drv1Chan == {1'b1, drv0Chan[4:0]})
        else $error("pair mismatch");
    a_done_low: assert property ((drv1Valid || drv0Valid) |-> !readDone)
        else $error("done high in read");
    a_last_chan: assert property ($fell(drv1Valid)
        |-> $past(drv1Chan) == 6'h20)
        else $error("drv1 last chan not 32");
    a_hiz_after: assert property (($fell(drv0Valid) && hiz_after_read_en)
        |-> ##[0:2] drv0Hiz)
        else $error("drv0 not hi-z");
    a_hiz_off: assert property (($fell(drv1Valid) && !hiz_after_read_en)
        |-> (!drv1Hiz)[*4])
        else $error("drv1 hi-z when off");
    a_ref_swap: assert property ($changed(integrate_polarity_n)
        |-> ##[1:3] refSwap == integrate_polarity_n)
        else $error("swap lags polarity");
endmodule : readout_checker

// file: verif/testbench.sv
// self-checking bench for the readout sequencer
`timescale 1ns/1ps
module testbench;
    import readout_pkg::*;
    logic                clk;
    logic                resetn;
    logic                parallel_out_select;
    logic                hiz_after_read_en;
    logic                integrate_polarity_n;
    wire logic           read_start_in, integrator_reset, signal_sample_strobe;
    wire logic           sampleValid, sampleReady;
    wire logic [5:0]     sampleChan, drv1Chan, drv0Chan;
    wire logic [15:0]    sampleData, drv1Data, drv0Data;
    wire logic           drv1Valid, drv1Hiz, drv0Valid, drv0Hiz;
    wire logic           refSwap, readDone, startOut;
    int                  nFail = 0;
    int                  checksDone = 0;

    readout_sequencer dut (
        .clk(clk), .resetn(resetn), .read_start_in(read_start_in),
        .integrator_reset(integrator_reset),
        .signal_sample_strobe(signal_sample_strobe),
        .parallel_out_select(parallel_out_select),
        .hiz_after_read_en(hiz_after_read_en),
        .integrate_polarity_n(integrate_polarity_n),
        .sampleValid(sampleValid), .sampleReady(sampleReady),
        .sampleChan(sampleChan), .sampleData(sampleData),
        .drv1Data(drv1Data), .drv1Chan(drv1Chan), .drv1Valid(drv1Valid),
        .drv1Hiz(drv1Hiz), .drv0Data(drv0Data), .drv0Chan(drv0Chan),
        .drv0Valid(drv0Valid), .drv0Hiz(drv0Hiz), .refSwap(refSwap),
        .readDone(readDone), .read_start_out(startOut));

    ctrl_adc_model ctrl (
        .clk(clk), .read_start_in(read_start_in),
        .integrator_reset(integrator_reset),
        .signal_sample_strobe(signal_sample_strobe),
        .sampleValid(sampleValid), .sampleReady(sampleReady),
        .sampleChan(sampleChan), .sampleData(sampleData),
        .drv1Data(drv1Data), .drv1Chan(drv1Chan), .drv1Valid(drv1Valid),
        .drv0Data(drv0Data), .drv0Chan(drv0Chan), .drv0Valid(drv0Valid));

    function automatic logic [15:0] expData(input int c);
        return {6'(c), 4'hA, ~6'(c)};
    endfunction : expData

    task automatic checkBit(input logic got, input logic exp, input string m);
        checksDone++;
        if (got !== exp) begin
            nFail++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : checkBit

    task automatic checkWord(input logic [15:0] got, input logic [15:0] exp,
                             input string m);
        checksDone++;
        if (got !== exp) begin
            nFail++;
            $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask : checkWord

    task automatic checkNum(input int got, input int lo, input int hi,
                            input string m);
        checksDone++;
        if (got < lo || got > hi) begin
            nFail++;
            $display("[FAIL] %0t %s count %0d", $time, m, got);
        end
    endtask : checkNum

    task automatic waitDone();
        repeat (8) @(posedge clk);
        for (int n = 0; n < 400 && readDone !== 1'b1; n++) @(posedge clk);
        repeat (4) @(posedge clk);
        #1;
    endtask : waitDone

    task automatic checkRead(input int perChan);
        int n = perChan * HALF_COUNT;
        checkNum(ctrl.cnt1, n, n, "d1");
        checkNum(ctrl.cnt0, n, n, "d0");
        checkWord({10'h000, ctrl.first1}, 16'h003F, "first on 1");
        checkWord({10'h000, ctrl.first0}, 16'h001F, "first on 0");
        for (int c = 0; c < CHAN_COUNT; c++) begin
            checkWord(ctrl.got[c], expData(c), "sample");
        end
        checkBit(readDone, 1'b1, "done");
    endtask : checkRead

    task automatic testFifoFill();
        int acc;
        bit ok;
        acc = 0;
        for (int c = 0; c < CHAN_COUNT; c++) begin
            ctrl.push(6'(c), expData(c), ok);
            if (!ok) break;
            acc++;
        end
        checkNum(acc, FIFO_DEPTH, FIFO_DEPTH + 1, "fifo depth");
        checkBit(sampleReady, 1'b0, "fifo full");
        ctrl.setShs(1'b1);
        for (int c = acc; c < CHAN_COUNT; c++) begin
            ctrl.push(6'(c), expData(c), ok);
            checkBit(ok, 1'b1, "taken");
        end
        repeat (20) @(posedge clk);
        #1;
        checkBit(sampleReady, 1'b1, "drained");
        ctrl.setShs(1'b0);
        repeat (6) @(posedge clk);
    endtask : testFifoFill

    task automatic testSeqRead();
        #1;
        hiz_after_read_en = 1'b1;
        ctrl.clearCap();
        ctrl.pulseStart(1'b0);
        waitDone();
        checkRead(SEQ_STEP_CLKS);
        checkBit(drv1Hiz, 1'b1, "drv1 hi-z");
        checkBit(drv0Hiz, 1'b1, "drv0 hi-z");
        ctrl.clearCap();
        repeat (40) @(posedge clk);
        checkNum(ctrl.cnt1 + ctrl.cnt0, 0, 0, "after last");
    endtask : testSeqRead

    task automatic testWaitState();
        #1;
        parallel_out_select = 1'b1;
        hiz_after_read_en = 1'b0;
        ctrl.clearCap();
        ctrl.pulseStart(1'b0);
        repeat (40) @(posedge clk);
        checkNum(ctrl.cnt1, 0, 0, "wait left");
        ctrl.pulseStart(1'b1);
        waitDone();
        checkRead(1);
        checkBit(drv1Hiz, 1'b0, "drv1 driven");
        checkBit(drv0Hiz, 1'b0, "drv0 driven");
    endtask : testWaitState

    task automatic testPolarity();
        @(posedge clk) #1;
        integrate_polarity_n = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        checkBit(refSwap, 1'b1, "swap");
        integrate_polarity_n = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        checkBit(refSwap, 1'b0, "no swap");
    endtask : testPolarity

    task automatic testAbort();
        @(posedge clk) #1;
        parallel_out_select = 1'b0;
        ctrl.pulseStart(1'b1);
        checkBit(startOut, 1'b1, "cascade high");
        repeat (30) @(posedge clk);
        #1;
        checkBit(startOut, 1'b0, "cascade low");
        resetn = 1'b0;
        #2;
        checkBit(drv1Valid, 1'b0, "reset valid");
        checkBit(readDone, 1'b1, "reset done");
        @(posedge clk);
        #1;
        resetn = 1'b1;
        repeat (4) @(posedge clk);
    endtask : testAbort

    task automatic end_sim();
        $display("checks %0d failures %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        resetn = 1'b0;
        parallel_out_select = 1'b0;
        hiz_after_read_en = 1'b0;
        integrate_polarity_n = 1'b0;
        repeat (4) @(posedge clk);
        checkBit(readDone, 1'b1, "done at reset");
        checkBit(drv0Valid, 1'b0, "valid at reset");
        checkBit(drv1Hiz, 1'b0, "hiz at reset");
        #1;
        resetn = 1'b1;
        testFifoFill();
        testSeqRead();
        testWaitState();
        testPolarity();
        testAbort();
        end_sim();
    end

    // scenarios need under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        nFail++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end
endmodule : testbench

bind readout_sequencer readout_checker u_chk (
    .clk(clk), .resetn(resetn), .parallel_out_select(parallel_out_select),
    .hiz_after_read_en(hiz_after_read_en),
    .integrate_polarity_n(integrate_polarity_n),
    .drv1Chan(drv1Chan), .drv1Valid(drv1Valid), .drv1Hiz(drv1Hiz),
    .drv0Chan(drv0Chan), .drv0Valid(drv0Valid), .drv0Hiz(drv0Hiz),
    .refSwap(refSwap), .readDone(readDone));
